// *** include/fpv_defines.vh ***
`ifndef FPV_DEFINES_VH
`define FPV_DEFINES_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define FPV_OFS_DUTY          8'h4c
`define FPV_OFS_FREQ          8'h4d
`define FPV_OFS_SHIFT         8'h4e

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define FPV_DUTY_EXT_MSB      7
`define FPV_DUTY_EXT_LSB      6
`define FPV_DUTY_BASE_MSB     5
`define FPV_DUTY_BASE_LSB     0
`define FPV_FREQ_DIV_MSB      4
`define FPV_FREQ_DIV_LSB      0
`define FPV_SHIFT_MSB         5
`define FPV_SHIFT_LSB         0

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define FPV_DUTY_RST          8'h00
`define FPV_FREQ_DIV_RST      5'h17
`define FPV_SHIFT_RST         6'h00

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define FPV_CLK_HZ            100000000
`define FPV_MCLK_FAST_HZ      360000
`define FPV_MCLK_SLOW_HZ      1400
`define FPV_MCLK_FAST_DIV     (`FPV_CLK_HZ / `FPV_MCLK_FAST_HZ)
`define FPV_MCLK_SLOW_DIV     (`FPV_CLK_HZ / `FPV_MCLK_SLOW_HZ)
`define FPV_DIV_W             17

`endif

// *** logic/fpv_tick_div.v ***
`include "fpv_defines.vh"

// ---------------------------------------------------------------
// divider: one-cycle enable every div_i clocks
// ---------------------------------------------------------------
module fpv_tick_div #(
	parameter W = `FPV_DIV_W
) (
	input  wire         ref_clk_i,
	input  wire         rstn_i,
	input  wire [W-1:0] div_i,
	output reg          tick_o
);

	reg [W-1:0] cnt;

	// restart on any count past the limit, so a lowered divisor
	// never waits for a wraparound
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt    <= {W{1'b0}};
			tick_o <= 1'b0;
		end else if (cnt >= div_i - {{(W-1){1'b0}}, 1'b1}) begin
			cnt    <= {W{1'b0}};
			tick_o <= 1'b1;
		end else begin
			cnt    <= cnt + {{(W-1){1'b0}}, 1'b1};
			tick_o <= 1'b0;
		end
	end

endmodule // fpv_tick_div

// *** logic/fpv_top.v ***
`include "fpv_defines.vh"

// How it works
// R1: program clear: duty reg read-only, shows table value
// R2: program set: duty reg writable, drives fan
// R3: duty reg reads zero during spin-up
// R4: duty reg: extension 7:6, base 5:0, reset zero
// R5: pwm frequency is master clock over 2n
// R6: master clock select picks fast or slow
// R7: divider value zero behaves as one
// R8: frequency field 4:0 read/write, reset 0x17
// R9: unused upper bits of 4d, 4e read zero
// R10: shift register 5:0 unsigned table offset
module fpv_top #(
	parameter MCLK_FAST_DIV = `FPV_MCLK_FAST_DIV,
	parameter MCLK_SLOW_DIV = `FPV_MCLK_SLOW_DIV
) (
	input  wire       ref_clk_i,
	input  wire       rstn_i,
	input  wire [7:0] reg_addr_i,
	input  wire       reg_wr_i,
	input  wire [7:0] reg_wdata_i,
	input  wire       reg_rd_i,
	output reg  [7:0] reg_rdata_o,
	output reg        reg_rvalid_o,
	input  wire       prog_mode_i,
	input  wire       mclk_sel_i,
	input  wire       spinup_active_i,
	input  wire [7:0] lut_duty_i,
	output reg  [5:0] lut_temp_shift_field_o,
	output reg  [7:0] duty_active_o,
	output reg        fan_pwm_o,
	output reg        fan_pwm_oen_o
);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	reg [1:0] duty_extension_bits;
	reg [5:0] duty_base_bits;
	reg [4:0] frequency_divider_field;
	reg [5:0] lut_temp_shift_field;

	// reset word split into its two fields
	localparam [7:0] DUTY_RST = `FPV_DUTY_RST;

	wire      wr_duty;
	wire      wr_freq;
	wire      wr_shift;

	assign wr_duty  = reg_wr_i && (reg_addr_i == `FPV_OFS_DUTY);
	assign wr_freq  = reg_wr_i && (reg_addr_i == `FPV_OFS_FREQ);
	assign wr_shift = reg_wr_i && (reg_addr_i == `FPV_OFS_SHIFT);

	// writes to the duty register are dropped while the table owns it
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			duty_extension_bits <= DUTY_RST[`FPV_DUTY_EXT_MSB:`FPV_DUTY_EXT_LSB]; // R4
			duty_base_bits      <= DUTY_RST[`FPV_DUTY_BASE_MSB:`FPV_DUTY_BASE_LSB]; // R4
		end else if (wr_duty && prog_mode_i) begin // R2
			duty_extension_bits <= reg_wdata_i[`FPV_DUTY_EXT_MSB:`FPV_DUTY_EXT_LSB];
			duty_base_bits      <= reg_wdata_i[`FPV_DUTY_BASE_MSB:`FPV_DUTY_BASE_LSB];
		end
	end

	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			frequency_divider_field <= `FPV_FREQ_DIV_RST; // R8
		end else if (wr_freq) begin
			frequency_divider_field <= reg_wdata_i[`FPV_FREQ_DIV_MSB:`FPV_FREQ_DIV_LSB]; // R8
		end
	end

	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lut_temp_shift_field <= `FPV_SHIFT_RST;
		end else if (wr_shift) begin
			lut_temp_shift_field <= reg_wdata_i[`FPV_SHIFT_MSB:`FPV_SHIFT_LSB]; // R10
		end
	end

	// ---------------------------------------------------------------
	// duty source
	// ---------------------------------------------------------------
	wire [7:0] duty_written;
	wire [7:0] duty_source;

	assign duty_written = {duty_extension_bits, duty_base_bits};
	assign duty_source  = prog_mode_i ? duty_written : lut_duty_i; // R1 R2

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	// spin-up masks the read only, the drive keeps its source
	reg [7:0] next_rdata;

	always @* begin
		next_rdata = 8'h00;
		case (reg_addr_i)
			`FPV_OFS_DUTY: begin
				if (spinup_active_i) begin
					next_rdata = 8'h00; // R3
				end else begin
					next_rdata = duty_source; // R1
				end
			end
			`FPV_OFS_FREQ: begin
				next_rdata = {3'h0, frequency_divider_field}; // R9
			end
			`FPV_OFS_SHIFT: begin
				next_rdata = {2'h0, lut_temp_shift_field}; // R9
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_rdata_o  <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= next_rdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// master clock enable
	// ---------------------------------------------------------------
	// divisors wider than the counter are cut to its width
	localparam [`FPV_DIV_W-1:0] FAST_DIV = MCLK_FAST_DIV[`FPV_DIV_W-1:0];
	localparam [`FPV_DIV_W-1:0] SLOW_DIV = MCLK_SLOW_DIV[`FPV_DIV_W-1:0];

	wire                  mclk_tick;
	wire [`FPV_DIV_W-1:0] mclk_div;

	// one divider serves both rates; a change of select takes
	// effect within one slow period at most
	assign mclk_div = mclk_sel_i ? FAST_DIV : SLOW_DIV; // R6

	fpv_tick_div #(
		.W (`FPV_DIV_W)
	) u_mclk (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.div_i     (mclk_div),
		.tick_o    (mclk_tick)
	);

	// ---------------------------------------------------------------
	// pwm period and duty
	// ---------------------------------------------------------------
	wire [4:0] div_eff;
	wire [5:0] period;

	assign div_eff = (frequency_divider_field == 5'h00) ? 5'h01 : frequency_divider_field; // R7
	assign period  = {div_eff, 1'b0}; // R5

	reg  [5:0] phase;
	reg  [1:0] frame;
	reg  [7:0] duty_latched;
	wire       end_of_period;
	wire [6:0] high_ticks;
	wire       dither;

	assign end_of_period = (phase >= period - 6'h01);

	// extension bits add one tick in that many of every four periods
	assign dither     = (frame < duty_latched[`FPV_DUTY_EXT_MSB:`FPV_DUTY_EXT_LSB]);
	assign high_ticks = {1'b0, duty_latched[`FPV_DUTY_BASE_MSB:`FPV_DUTY_BASE_LSB]}
		+ {6'h00, dither};

	// duty is taken at period start so a write never cuts a pulse
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			phase        <= 6'h00;
			frame        <= 2'h0;
			duty_latched <= `FPV_DUTY_RST;
		end else if (mclk_tick) begin
			if (end_of_period) begin // R5
				phase        <= 6'h00;
				frame        <= frame + 2'h1;
				duty_latched <= duty_source; // R2
			end else begin
				phase <= phase + 6'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// open-drain pin
	// ---------------------------------------------------------------
	// duty above the period length saturates at full on
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fan_pwm_o     <= 1'b0;
			fan_pwm_oen_o <= 1'b0;
		end else begin
			fan_pwm_o     <= 1'b0;
			fan_pwm_oen_o <= ({1'b0, phase} < high_ticks);
		end
	end

	// ---------------------------------------------------------------
	// status outputs
	// ---------------------------------------------------------------
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lut_temp_shift_field_o <= `FPV_SHIFT_RST;
			duty_active_o          <= `FPV_DUTY_RST;
		end else begin
			lut_temp_shift_field_o <= lut_temp_shift_field; // R10
			duty_active_o          <= duty_latched;
		end
	end

endmodule // fpv_top

// *** sim/fan_pwm_value_and_frequency_bench.sv ***
module fan_pwm_value_and_frequency_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       ref_clk_i = 1'b0;
	logic       rstn_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic       reg_wr_i = 1'b0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic       reg_rd_i = 1'b0;
	logic       prog_mode_i = 1'b1;
	logic       mclk_sel_i = 1'b0;
	logic       spinup_active_i = 1'b0;
	logic [7:0] lut_duty_i = 8'h00;
	wire  [7:0] reg_rdata_o;
	wire        reg_rvalid_o;
	wire        fan_pwm_oen_o;
	int         period_m, high_m, a, d, n;
	int         err_total = 0;
	int         tests_run = 0;
	int         seed = 32'h2ea9;
	int         duty_m = 0, freq_m = 8'h17, shift_m = 0;
	// small dividers keep the pwm periods short
	fpv_top #(.MCLK_FAST_DIV(4), .MCLK_SLOW_DIV(8)) DUT (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .prog_mode_i(prog_mode_i),
		.mclk_sel_i(mclk_sel_i), .spinup_active_i(spinup_active_i), .lut_duty_i(lut_duty_i),
		.lut_temp_shift_field_o(), .duty_active_o(), .fan_pwm_o(),
		.fan_pwm_oen_o(fan_pwm_oen_o));
	fpv_fan_model FAN (.ref_clk_i(ref_clk_i), .fan_pwm_oen_i(fan_pwm_oen_o),
		.period_o(period_m), .high_o(high_m));
	always #5 ref_clk_i = ~ref_clk_i;
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [7:0] ad, input logic [7:0] dt);
		@(negedge ref_clk_i);
		reg_addr_i = ad;
		reg_wdata_i = dt;
		reg_wr_i = 1'b1;
		@(negedge ref_clk_i);
		reg_wr_i = 1'b0;
		if (ad == 8'h4c && prog_mode_i) duty_m = dt;
		if (ad == 8'h4d) freq_m = dt & 8'h1f;
		if (ad == 8'h4e) shift_m = dt & 8'h3f;
	endtask
	task rd(input logic [7:0] ad);
		logic [7:0] e;
		e = (ad == 8'h4d) ? freq_m : (ad == 8'h4e) ? shift_m : 8'h00;
		if (ad == 8'h4c) e = spinup_active_i ? 8'h00 : prog_mode_i ? duty_m : lut_duty_i;
		@(negedge ref_clk_i);
		reg_addr_i = ad;
		reg_rd_i = 1'b1;
		@(negedge ref_clk_i);
		reg_rd_i = 1'b0;
		chk("rvalid", reg_rvalid_o, 1);
		chk("rdata", reg_rdata_o, e);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		err_total++;
		final_report();
	end
	initial begin
		repeat (8) @(negedge ref_clk_i);
		rstn_i = 1'b1;
		for (int i = 0; i < 4; i++) rd(8'h4c + i);
		for (int i = 0; i < 60; i++) begin
			a = $random(seed);
			d = $random(seed);
			@(negedge ref_clk_i);
			prog_mode_i = a[8];
			spinup_active_i = a[9] & a[10];
			lut_duty_i = a[23:16];
			wr(8'h4c + a[1:0], d[7:0]);
			rd(8'h4c + a[5:4]);
		end
		spinup_active_i = 1'b0;
		prog_mode_i = 1'b1;
		// ext bits kept clear so no dither
		for (int i = 0; i < 6; i++) begin
			n = (i % 3 == 2) ? 3 : i % 3;
			mclk_sel_i = (i > 2);
			wr(8'h4d, n[7:0]);
			wr(8'h4c, 8'h01);
			repeat (200) @(negedge ref_clk_i);
			chk("period", period_m, 2 * (n ? n : 1) * (mclk_sel_i ? 4 : 8));
			chk("high", high_m, mclk_sel_i ? 4 : 8);
		end
		final_report();
	end
endmodule // fan_pwm_value_and_frequency_bench

// *** sim/fpv_fan_model.sv ***
module fpv_fan_model (
	input  wire ref_clk_i,
	input  wire fan_pwm_oen_i,
	output int  period_o,
	output int  high_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// released line floats up through the pull-up
	wire  pin = fan_pwm_oen_i ? 1'b1 : 1'b0;
	logic last = 1'b0;
	int   cnt = 0;
	int   hi = 0;
	always @(posedge ref_clk_i) begin
		last <= pin;
		if (pin && !last) begin
			period_o <= cnt;
			high_o <= hi;
			cnt <= 1;
			hi <= 1;
		end else begin
			cnt <= cnt + 1;
			hi <= hi + pin;
		end
	end
endmodule // fpv_fan_model

// *** sim/fpv_top_chk.sv ***
module fpv_top_chk #(
	parameter MCLK_FAST_DIV = 4,
	parameter MCLK_SLOW_DIV = 8
) (
	input wire       ref_clk_i,
	input wire       rstn_i,
	input wire [7:0] reg_addr_i,
	input wire       reg_wr_i,
	input wire [7:0] reg_wdata_i,
	input wire       reg_rd_i,
	input wire [7:0] reg_rdata_o,
	input wire       reg_rvalid_o,
	input wire       prog_mode_i,
	input wire       spinup_active_i,
	input wire [7:0] lut_duty_i,
	input wire [5:0] lut_temp_shift_field_o,
	input wire [7:0] duty_active_o,
	input wire       fan_pwm_o,
	input wire       fan_pwm_oen_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no read answer");
	no_stray_a: assert property (!reg_rd_i |=> !reg_rvalid_o) else $error("stray answer");
	spin_zero_a: assert property (reg_rd_i && reg_addr_i == 8'h4c && spinup_active_i
		|=> reg_rdata_o == 8'h00) else $error("duty not zero in spin-up");
	lut_track_a: assert property (reg_rd_i && reg_addr_i == 8'h4c && !prog_mode_i
		&& !spinup_active_i |=> reg_rdata_o == $past(lut_duty_i)) else $error("duty not table");
	freq_upper_a: assert property (reg_rd_i && reg_addr_i == 8'h4d
		|=> reg_rdata_o[7:5] == 3'h0) else $error("freq upper bits set");
	shift_upper_a: assert property (reg_rd_i && reg_addr_i == 8'h4e
		|=> reg_rdata_o[7:6] == 2'h0) else $error("shift upper bits set");
	shift_write_a: assert property (reg_wr_i && reg_addr_i == 8'h4e
		|=> ##1 {2'h0, lut_temp_shift_field_o} == ($past(reg_wdata_i, 2) & 8'h3f))
		else $error("shift field not loaded");
	oen_rise_a: assert property ($rose(fan_pwm_oen_o) |-> duty_active_o != 8'h00)
		else $error("pin released at zero duty");
	pin_low_a: assert property (fan_pwm_o == 1'b0)
		else $error("open-drain pin value not low");
	cover property (reg_rd_i && reg_addr_i == 8'h4c && spinup_active_i);
	cover property (reg_wr_i && reg_addr_i == 8'h4c && prog_mode_i);
	cover property ($rose(fan_pwm_oen_o));
endmodule // fpv_top_chk

bind fpv_top fpv_top_chk #(.MCLK_FAST_DIV(MCLK_FAST_DIV), .MCLK_SLOW_DIV(MCLK_SLOW_DIV)) u_chk (.*);
